// ---- dv/ffmd_chk_sva.sv ----
// concurrent checks on the freefall and motion detector ports
`timescale 1ns/10ps
`default_nettype none
`include "ffmd_consts.svh"
module ffmd_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt requests
  input wire ffmd_pkg::ffmd_irq_t irq_req
);
  import ffmd_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [29:0] idx_q;
  logic [7:0] cfg_q;
  logic src_rd;
  logic mapped;
  logic [5:0] off_mask;
  assign src_rd = idx_q == `FFMD_IDX_SOURCE;
  assign mapped = idx_q >= `FFMD_IDX_CONFIG && idx_q <= `FFMD_IDX_SYSCTRL;
  assign off_mask = ~{{2{cfg_q[5]}}, {2{cfg_q[4]}}, {2{cfg_q[3]}}};
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) idx_q <= s_axi_araddr[31:2];
    if (!aresetn) cfg_q <= 8'h00;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready && s_axi_awaddr[31:2] == `FFMD_IDX_CONFIG)
      cfg_q <= s_axi_wdata[7:0];
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("response dropped");
  chk_src_layout: assert property (s_axi_rvalid && src_rd |->
    s_axi_rdata[31:8] == 0 && !s_axi_rdata[6]) else $error("source bits");
  chk_axis_mask: assert property (s_axi_rvalid && src_rd |->
    (s_axi_rdata[5:0] & off_mask) == 0) else $error("disabled axis flag");
  chk_off_idle: assert property (s_axi_rvalid && src_rd &&
    cfg_q[5:3] == 0 |-> !s_axi_rdata[7]) else $error("event while off");
  chk_unmapped_err: assert property (s_axi_rvalid && !mapped |->
    s_axi_rresp == `FFMD_RESP_SLVERR && s_axi_rdata == 0)
    else $error("unmapped read");
  chk_irq_route: assert property (!(irq_req.pin1 && irq_req.pin2))
    else $error("both pins requested");
endmodule
bind ffmd_top ffmd_chk i_chk (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq_req);
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking testbench for the freefall and motion detector
`timescale 1ns/10ps
`default_nettype none
`include "ffmd_consts.svh"
module testbench;
  import ffmd_pkg::*;
  localparam logic [29:0] CF = `FFMD_IDX_CONFIG;
  localparam logic [29:0] SR = `FFMD_IDX_SOURCE;
  localparam logic [29:0] TH = `FFMD_IDX_THRESHOLD;
  localparam logic [29:0] DB = `FFMD_IDX_DEBOUNCE;
  localparam logic [29:0] SY = `FFMD_IDX_SYSCTRL;
  localparam logic [1:0] OK = `FFMD_RESP_OKAY;
  localparam logic [1:0] ER = `FFMD_RESP_SLVERR;
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] wstrb = 4'hf;
  logic [2:0] prot = 3'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  ffmd_sample_t smp = '0;
  ffmd_irq_t irq;
  int fails = 0;
  int total_checks = 0;
  logic [2:0] pol = 0;
  ffmd_top #(.STEP_CAP_NORMAL_CYC(400), .STEP_CAP_LOW_POWER_LOW_NOISE_MODE_CYC(80),
    .STEP_CAP_HIRES_CYC(10), .STEP_CAP_LP_CYC(160)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(prot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(prot),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_in(smp), .irq_req(irq));
  initial forever #2.5 aclk = ~aclk;
  task automatic conclude;
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [29:0] i, logic [7:0] d, logic [1:0] e);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    chk("bresp", {6'h0, e}, {6'h0, bresp});
  endtask
  task automatic rd(logic [29:0] i, logic [7:0] e, logic [1:0] er, string n);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1;
    rready <= 1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    chk(n, e, rdata[7:0]);
    chk("rresp", {6'h0, er}, {6'h0, rresp});
  endtask
  task automatic step(logic [11:0] x, logic [11:0] y, logic [11:0] z);
    @(posedge aclk);
    smp <= {1'b1, x, y, z};
    @(posedge aclk);
    smp.strobe <= 0;
    repeat (3) @(posedge aclk);
  endtask
  function automatic logic hi(logic [11:0] v, logic [6:0] t);
    logic [11:0] m;
    m = v[11] ? -v : v;
    return m[11:4] > {1'b0, t};
  endfunction
  task automatic src_chk(logic ea, logic [2:0] en, logic [2:0] h, int n);
    logic [7:0] e;
    e = {ea, 7'h00};
    for (int k = 0; k < 3; k++) e[2*k +: 2] = {h[k], pol[k]} & {2{en[k]}};
    chk("irq", {6'h0, ea, 1'b0}, {6'h0, irq});
    for (int r = 0; r < n; r++) rd(SR, e, OK, "source");
  endtask
  initial begin
    logic [2:0] en, h;
    logic [6:0] t;
    logic [11:0] s [3];
    logic c;
    void'($urandom(32'h8269fe6f));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 5; i++)
      rd(CF + 30'(i), 8'h00, OK, "reset");
    rd(30'h1a, 8'h00, ER, "unmapped");
    wr(SR, 8'hff, OK);
    rd(SR, 8'h00, OK, "source ro");
    wr(TH, 8'hab, OK);
    rd(TH, 8'hab, OK, "threshold");
    wstrb <= 4'he;
    wr(TH, 8'h12, OK);
    rd(TH, 8'hab, OK, "strobe off");
    wstrb <= 4'hf;
    wr(DB, 8'hff, OK);
    rd(DB, 8'hff, OK, "count");
    wr(DB, 8'h00, OK);
    wr(SY, 8'h43, OK);
    for (int i = 0; i < 40; i++) begin
      prot <= 3'($urandom);
      en = 3'($urandom);
      c = 1'($urandom);
      t = 7'($urandom);
      if (i % 8 == 0) t = i[3] ? 7'h7f : 7'h00;
      foreach (s[k]) s[k] = 12'($urandom);
      if (i % 5 == 0) s[0] = {1'b0, t, 4'hf};
      wr(CF, {1'b0, c, en, 3'b000}, OK);
      wr(TH, {1'b1, t}, OK);
      step(s[0], s[1], s[2]);
      foreach (s[k]) h[k] = hi(s[k], t);
      foreach (s[k]) if (h[k]) pol[k] = s[k][11];
      src_chk(c ? |(h & en) : en != 0 && (h & en) == 0,
              en, h, 2);
    end
    wr(CF, 8'h48, OK);
    wr(DB, 8'h03, OK);
    pol[0] = 1'b0;
    for (int m = 0; m < 2; m++) begin
      wr(TH, {m[0], 7'h10}, OK);
      step(12'h000, 12'h000, 12'h000);
      for (int k = 0; k < 5; k++) begin
        step(12'h7ff, 12'h000, 12'h000);
        src_chk(k >= 2, 3'b001, 3'b001, 1);
      end
      for (int k = 0; k < 3; k++) begin
        step(12'h000, 12'h000, 12'h000);
        src_chk(m == 0 && k < 2, 3'b001, 3'b000, 1);
      end
    end
    wr(DB, 8'h00, OK);
    wr(CF, 8'hd8, OK);
    step(12'h800, 12'h000, 12'h000);
    step(12'h000, 12'h7ff, 12'h000);
    rd(SR, {5'h10, pol[1], 2'b11}, OK, "latched");
    rd(SR, 8'h00, OK, "cleared");
    step(12'h000, 12'h7ff, 12'h000);
    rd(SR, 8'h88, OK, "relatched");
    pol = 3'b000;
    wr(SY, 8'h47, OK);
    rd(SY, 8'h47, OK, "sysctrl");
    wr(CF, 8'h48, OK);
    wr(TH, 8'hff, OK);
    step(12'h500, 12'h000, 12'h000);
    src_chk(1'b1, 3'b001, 3'b001, 1);
    wr(TH, 8'h8f, OK);
    wr(DB, 8'h04, OK);
    wr(SY, 8'h13, OK);
    step(12'h3ff, 12'h000, 12'h000);
    src_chk(1'b0, 3'b001, 3'b000, 1);
    step(12'h400, 12'h000, 12'h000);
    src_chk(1'b0, 3'b001, 3'b001, 1);
    repeat (50) @(posedge aclk);
    src_chk(1'b1, 3'b001, 3'b001, 1);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    conclude();
  end
endmodule
`default_nettype wire

// ---- src/ffmd_consts.svh ----
// register map, field positions, reset values and timing constants
`ifndef FFMD_CONSTS_SVH
`define FFMD_CONSTS_SVH

// register indices; byte address is four times the index
`define FFMD_IDX_CONFIG 30'h15
`define FFMD_IDX_SOURCE 30'h16
`define FFMD_IDX_THRESHOLD 30'h17
`define FFMD_IDX_DEBOUNCE 30'h18
`define FFMD_IDX_SYSCTRL 30'h19

// configuration register fields
`define FFMD_CFG_LATCH 7
`define FFMD_CFG_COMBINE 6
`define FFMD_CFG_ZEN 5
`define FFMD_CFG_YEN 4
`define FFMD_CFG_XEN 3
`define FFMD_CFG_MASK 8'hf8

// threshold register fields
`define FFMD_THS_MODE 7
`define FFMD_THS_VAL_MSB 6

// system control register fields
`define FFMD_SYS_IRQ_EN 0
`define FFMD_SYS_ROUTE 1
`define FFMD_SYS_LOWNOISE 2
`define FFMD_SYS_OS_LSB 3
`define FFMD_SYS_FS_LSB 5
`define FFMD_SYS_MASK 8'h7f

// reset values
`define FFMD_RST_BYTE 8'h00
`define FFMD_RST_CNT 32'h0000_0000

// largest threshold with the low-noise bit set (4 g)
`define FFMD_THS_LOWNOISE_MAX 8'h40

// magnitude shift per full-scale setting (2 g, 4 g, 8 g)
`define FFMD_SHIFT_2G 6
`define FFMD_SHIFT_4G 5
`define FFMD_SHIFT_8G 4

// axi responses
`define FFMD_RESP_OKAY 2'b00
`define FFMD_RESP_SLVERR 2'b10

// clock and longest debounce step per oversampling mode
`define FFMD_CLK_MHZ 200
`define FFMD_STEP_NORMAL_US 20000
`define FFMD_STEP_LOW_POWER_LOW_NOISE_MODE_US 80000
`define FFMD_STEP_HIRES_US 2500
`define FFMD_STEP_LP_US 160000

`endif

// ---- src/ffmd_pkg.sv ----
// types shared by the freefall and motion detector
package ffmd_pkg;

  typedef enum logic [1:0] {
    ffmd_os_normal,
    ffmd_os_low_power_low_noise_mode,
    ffmd_os_hires,
    ffmd_os_lp
  } ffmd_os_mode_t;

  typedef struct packed {
    logic strobe;
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } ffmd_sample_t;

  typedef struct packed {
    logic pin1;
    logic pin2;
  } ffmd_irq_t;

endpackage

// ---- src/ffmd_top.sv ----
// freefall and motion detector with axi4-lite register slave
// Contract
// - source register: active bit 7, zero bit 6, z/y/x event and polarity
// - axis event and polarity read zero while that axis enable is clear
// - polarity is 0 for positive sample, 1 for negative sample
// - event-active sets when combined condition holds and debounce completes
// - event-active gated by interrupt enable and routing makes the request
// - axis motion true when sample magnitude strictly above threshold
// - freefall true only when all enabled magnitudes at or below threshold
// - threshold register: mode select bit 7, 7-bit threshold, reset zero
// - threshold 0.063 g per count, up to 8 g at every full scale
// - low-noise bit limits the usable threshold to 4 g
// - mode select 1 clears the debounce counter when condition false
// - mode select 0 decrements counter when false, stopping at zero
// - debounce count register: 8-bit read/write, resets to zero
// - event flag sets when counter reaches the debounce count
// - debounce counter saturates at the programmed count
// - one debounce step per output sample period
// - debounce step capped at 2.5, 20, 80 or 160 ms by mode
// - combine select 0 ands low conditions, 1 ors high conditions
// - with latch, flags freeze on event; source read clears all
// - without latch, source read leaves event-active following debounce
// - all three axis enables clear disables detection
`timescale 1ns/10ps
`default_nettype none
`include "ffmd_consts.svh"

module ffmd_top #(
  parameter int unsigned STEP_CAP_NORMAL_CYC =
    `FFMD_STEP_NORMAL_US * `FFMD_CLK_MHZ,
  parameter int unsigned STEP_CAP_LOW_POWER_LOW_NOISE_MODE_CYC =
    `FFMD_STEP_LOW_POWER_LOW_NOISE_MODE_US * `FFMD_CLK_MHZ,
  parameter int unsigned STEP_CAP_HIRES_CYC =
    `FFMD_STEP_HIRES_US * `FFMD_CLK_MHZ,
  parameter int unsigned STEP_CAP_LP_CYC =
    `FFMD_STEP_LP_US * `FFMD_CLK_MHZ
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // samples from the data path
  input wire ffmd_pkg::ffmd_sample_t sample_in,
  // interrupt requests
  output var ffmd_pkg::ffmd_irq_t irq_req
);
  import ffmd_pkg::*;

  // address match against a register index
  function automatic logic reg_hit(input logic [31:0] addr,
                                   input logic [29:0] idx);
    reg_hit = (addr[31:2] == idx);
  endfunction

  // magnitude in threshold counts of one signed sample
  function automatic logic [7:0] axis_mag(input logic [11:0] s,
                                          input logic [1:0] fs);
    logic [11:0] a;
    a = s[11] ? 12'(~s + 12'h001) : s;
    case (fs)
      2'h0: axis_mag = 8'(a >> `FFMD_SHIFT_2G);
      2'h1: axis_mag = 8'(a >> `FFMD_SHIFT_4G);
      default: axis_mag = 8'(a >> `FFMD_SHIFT_8G);
    endcase
  endfunction

  // longest debounce step for the oversampling mode
  function automatic logic [31:0] step_cap(input ffmd_os_mode_t m);
    case (m)
      ffmd_os_normal: step_cap = 32'(STEP_CAP_NORMAL_CYC);
      ffmd_os_low_power_low_noise_mode: step_cap = 32'(STEP_CAP_LOW_POWER_LOW_NOISE_MODE_CYC);
      ffmd_os_hires: step_cap = 32'(STEP_CAP_HIRES_CYC);
      default: step_cap = 32'(STEP_CAP_LP_CYC);
    endcase
  endfunction

  // registers
  logic [7:0] cfg_reg;
  logic [7:0] ths_reg;
  logic [7:0] count_reg;
  logic [7:0] sys_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic ea_reg;
  logic ea_next;
  logic [2:0] evt_reg;
  logic [2:0] evt_next;
  logic [2:0] pol_reg;
  logic [2:0] pol_next;
  logic [31:0] tmr_reg;
  logic [31:0] tmr_next;
  logic [11:0] x_reg;
  logic [11:0] y_reg;
  logic [11:0] z_reg;

  // bus state
  logic aw_hold_reg;
  logic [31:0] aw_addr_reg;
  logic w_hold_reg;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rdata_reg;

  // write channel handshakes
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire wr_cfg = wr_fire && w_strb_reg &&
                reg_hit(aw_addr_reg, `FFMD_IDX_CONFIG);
  wire wr_ths = wr_fire && w_strb_reg &&
                reg_hit(aw_addr_reg, `FFMD_IDX_THRESHOLD);
  wire wr_cnt = wr_fire && w_strb_reg &&
                reg_hit(aw_addr_reg, `FFMD_IDX_DEBOUNCE);
  wire wr_sys = wr_fire && w_strb_reg &&
                reg_hit(aw_addr_reg, `FFMD_IDX_SYSCTRL);
  wire wr_known = reg_hit(aw_addr_reg, `FFMD_IDX_CONFIG) ||
                  reg_hit(aw_addr_reg, `FFMD_IDX_SOURCE) ||
                  reg_hit(aw_addr_reg, `FFMD_IDX_THRESHOLD) ||
                  reg_hit(aw_addr_reg, `FFMD_IDX_DEBOUNCE) ||
                  reg_hit(aw_addr_reg, `FFMD_IDX_SYSCTRL);

  // read channel handshakes
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_cfg = reg_hit(s_axi_araddr, `FFMD_IDX_CONFIG);
  wire rd_src = reg_hit(s_axi_araddr, `FFMD_IDX_SOURCE);
  wire rd_ths = reg_hit(s_axi_araddr, `FFMD_IDX_THRESHOLD);
  wire rd_cnt = reg_hit(s_axi_araddr, `FFMD_IDX_DEBOUNCE);
  wire rd_sys = reg_hit(s_axi_araddr, `FFMD_IDX_SYSCTRL);
  wire rd_known = rd_cfg || rd_src || rd_ths || rd_cnt || rd_sys;

  // configuration fields
  wire latch_enable = cfg_reg[`FFMD_CFG_LATCH];
  wire combine_select = cfg_reg[`FFMD_CFG_COMBINE];
  wire [2:0] axis_en = {cfg_reg[`FFMD_CFG_ZEN], cfg_reg[`FFMD_CFG_YEN],
                        cfg_reg[`FFMD_CFG_XEN]};
  wire debounce_mode_select = ths_reg[`FFMD_THS_MODE];
  wire [6:0] threshold_value = ths_reg[`FFMD_THS_VAL_MSB:0];
  wire motion_interrupt_enable = sys_reg[`FFMD_SYS_IRQ_EN];
  wire motion_interrupt_route = sys_reg[`FFMD_SYS_ROUTE];
  wire low_noise = sys_reg[`FFMD_SYS_LOWNOISE];
  wire ffmd_os_mode_t os_mode =
    ffmd_os_mode_t'(sys_reg[`FFMD_SYS_OS_LSB +: 2]);
  wire [1:0] full_scale = sys_reg[`FFMD_SYS_FS_LSB +: 2];

  // source read clears under latch
  wire src_clear = ar_take && rd_src && latch_enable;

  // debounce step: each sample, or the mode cap if samples are slower
  wire [31:0] cap_cyc = step_cap(os_mode);
  wire cap_hit = (tmr_reg >= cap_cyc - 32'h0000_0001);
  wire step = sample_in.strobe || cap_hit;
  wire [11:0] x_cur = sample_in.strobe ? sample_in.x : x_reg;
  wire [11:0] y_cur = sample_in.strobe ? sample_in.y : y_reg;
  wire [11:0] z_cur = sample_in.strobe ? sample_in.z : z_reg;
  wire [11:0] sgn_word = {x_cur[11], y_cur[11], z_cur[11], 9'h000};
  assign tmr_next = step ? `FFMD_RST_CNT : tmr_reg + 32'h0000_0001;

  // threshold comparison, 8 g span at all full scales
  wire [7:0] eff_ths = (low_noise &&
                        {1'b0, threshold_value} > `FFMD_THS_LOWNOISE_MAX)
                       ? `FFMD_THS_LOWNOISE_MAX
                       : {1'b0, threshold_value};
  wire [7:0] mag_x = axis_mag(x_cur, full_scale);
  wire [7:0] mag_y = axis_mag(y_cur, full_scale);
  wire [7:0] mag_z = axis_mag(z_cur, full_scale);
  wire [2:0] axis_hi = {mag_z > eff_ths, mag_y > eff_ths,
                        mag_x > eff_ths};
  wire [2:0] axis_neg = {sgn_word[9], sgn_word[10], sgn_word[11]};

  // combined condition
  wire any_en = |axis_en;
  wire cond_motion = |(axis_hi & axis_en);
  wire cond_free = &(~axis_hi | ~axis_en);
  wire cond = any_en && (combine_select ? cond_motion : cond_free);

  // debounce counter arithmetic
  wire frozen = latch_enable && ea_reg;
  wire [7:0] cnt_inc = (cnt_reg < count_reg) ? cnt_reg + 8'h01
                                             : count_reg;
  wire [7:0] cnt_dec = (cnt_reg == 8'h00) ? 8'h00
                                          : cnt_reg - 8'h01;
  wire [7:0] cnt_step = cond ? cnt_inc
                      : (debounce_mode_select ? 8'h00 : cnt_dec);
  wire do_step = step && !frozen;
  wire ea_set = do_step && cond && (cnt_step == count_reg);
  wire ea_clr = latch_enable ? src_clear
              : (do_step && !cond && cnt_step == 8'h00);

  assign cnt_next = do_step ? cnt_step
                  : (src_clear ? 8'h00 : cnt_reg);
  assign ea_next = ea_set || (ea_reg && !ea_clr);
  assign evt_next = do_step ? axis_hi
                  : (src_clear ? 3'h0 : evt_reg);
  assign pol_next = do_step ? ((axis_hi & axis_neg) | (~axis_hi & pol_reg))
                  : (src_clear ? 3'h0 : pol_reg);

  // source byte with per-axis masking
  wire [2:0] evt_vis = evt_reg & axis_en;
  wire [2:0] pol_vis = pol_reg & axis_en;
  wire [7:0] src_byte = {ea_reg, 1'b0, evt_vis[2], pol_vis[2],
                         evt_vis[1], pol_vis[1],
                         evt_vis[0], pol_vis[0]};
  wire [7:0] rd_byte = rd_cfg ? cfg_reg
                     : rd_src ? src_byte
                     : rd_ths ? ths_reg
                     : rd_cnt ? count_reg
                     : rd_sys ? sys_reg : `FFMD_RST_BYTE;

  // bus outputs
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = {24'h00_0000, rdata_reg};

  // interrupt requests
  assign irq_req.pin1 = ea_reg && motion_interrupt_enable &&
                        motion_interrupt_route;
  assign irq_req.pin2 = ea_reg && motion_interrupt_enable &&
                        !motion_interrupt_route;

  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= `FFMD_RST_CNT;
      w_hold_reg <= 1'b0;
      w_data_reg <= `FFMD_RST_BYTE;
      w_strb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `FFMD_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_reg <= 1'b0;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? `FFMD_RESP_OKAY : `FFMD_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `FFMD_RESP_OKAY;
      rdata_reg <= `FFMD_RST_BYTE;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_known ? `FFMD_RESP_OKAY : `FFMD_RESP_SLVERR;
      rdata_reg <= rd_byte;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= `FFMD_RST_BYTE;
      ths_reg <= `FFMD_RST_BYTE;
      count_reg <= `FFMD_RST_BYTE;
      sys_reg <= `FFMD_RST_BYTE;
    end else begin
      if (wr_cfg) cfg_reg <= w_data_reg & `FFMD_CFG_MASK;
      if (wr_ths) ths_reg <= w_data_reg;
      if (wr_cnt) count_reg <= w_data_reg;
      if (wr_sys) sys_reg <= w_data_reg & `FFMD_SYS_MASK;
    end
  end

  // detector state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= `FFMD_RST_BYTE;
      ea_reg <= 1'b0;
      evt_reg <= 3'h0;
      pol_reg <= 3'h0;
      tmr_reg <= `FFMD_RST_CNT;
      x_reg <= 12'h000;
      y_reg <= 12'h000;
      z_reg <= 12'h000;
    end else begin
      cnt_reg <= cnt_next;
      ea_reg <= ea_next;
      evt_reg <= evt_next;
      pol_reg <= pol_next;
      tmr_reg <= tmr_next;
      x_reg <= x_cur;
      y_reg <= y_cur;
      z_reg <= z_cur;
    end
  end

endmodule
`default_nettype wire
